// ==== core/ext_mem_pkg.sv ====
// constants for the external data memory interface
package ext_mem_pkg;
  // ******************************
  // register map (index, byte address = 4 * index)
  // ******************************
  localparam int unsigned ADR_W        = 12;
  localparam logic [9:0]  IDX_CONFIG   = 10'h0a3;
  localparam logic [9:0]  IDX_PAGE     = 10'h0a2;
  localparam logic [9:0]  IDX_TIMING   = 10'h0a1;
  localparam logic [9:0]  IDX_STATUS   = 10'h0a4;
  // ******************************
  // reset values
  // ******************************
  localparam logic [7:0]  CONFIG_RST   = 8'h03;
  localparam logic [7:0]  CONFIG_MASK  = 8'h3f;
  localparam logic [7:0]  PAGE_RST     = 8'h00;
  localparam logic [7:0]  TIMING_RST   = 8'hff;
  // ******************************
  // config fields
  // ******************************
  localparam int unsigned CF_PORT_SEL  = 5;
  localparam int unsigned CF_MUX_SEL   = 4;
  localparam int unsigned CF_MODE_HI   = 3;
  localparam int unsigned CF_MODE_LO   = 2;
  localparam int unsigned CF_ALE_HI    = 1;
  localparam int unsigned CF_ALE_LO    = 0;
  // ******************************
  // timing fields
  // ******************************
  localparam int unsigned TC_SETUP_HI  = 7;
  localparam int unsigned TC_SETUP_LO  = 6;
  localparam int unsigned TC_STRB_HI   = 5;
  localparam int unsigned TC_STRB_LO   = 2;
  localparam int unsigned TC_HOLD_HI   = 1;
  localparam int unsigned TC_HOLD_LO   = 0;
  // ******************************
  // memory map
  // ******************************
  localparam logic [1:0]  MODE_INT     = 2'h0;
  localparam logic [1:0]  MODE_SPLIT   = 2'h1;
  localparam logic [1:0]  MODE_BANK    = 2'h2;
  localparam logic [1:0]  MODE_EXT     = 2'h3;
  localparam logic [15:0] ONCHIP_TOP   = 16'h2000;
  localparam int unsigned ON_CHIP_EXT_RAM_AW      = 13;
  // ******************************
  // timing counts
  // ******************************
  localparam logic [3:0]  FIN_LAST     = 4'h2;
  localparam int unsigned CNT_W        = 4;
  typedef enum logic [2:0] {
    st_idle, st_start, st_ale_hi, st_ale_lo,
    st_setup, st_strobe, st_hold, st_fin
  } xfer_state_type;
endpackage

// ==== core/phase_timer.sv ====
// down counter timing one phase of an off-chip transfer
`timescale 1ns/100ps
module phase_timer #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              zero_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign zero_o = (cnt_q == '0);
endmodule // phase_timer

// ==== core/ext_mem_if.sv ====
// external data memory interface: config registers, routing, pin timing
// How it works
// - port select bit 5: 0 lower port group, 1 upper port group
// - bit 4: 0 shared address/data pins, 1 separate pins
// - mode 00: all accesses on-chip, address wraps modulo 8 kB
// - split modes: below 8 kB on-chip, above off-chip
// - split no-bank 8-bit off-chip: low byte driven, high pins left alone
// - split no-bank 8-bit decision uses page byte with low byte
// - 16-bit split access decides on pointer, drives all sixteen lines
// - mode 10 8-bit off-chip: high byte from page, all lines driven
// - mode 11: every access off-chip, on-chip RAM hidden
// - mode 11 8-bit: page ignored, high pins undriven
// - mode 00 8-bit address is page plus low byte; 16-bit uses pointer
// - latch strobe high and low each 1..4 clocks, muxed mode only
// - muxed: strobe high with low address, then pins carry data
// - transfer length is setup plus strobe field plus hold plus five clocks
// - muxed mode adds latch phase, at least seven clocks total
// - timing resets to maximum, config resets to 00000011
// - config bits 7..6 read zero, writes ignored
// - pins owned only during an off-chip transfer
// - setup field gives 0..3 clocks of address setup
// - data drivers off while pins act as inputs
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module ext_mem_if
  import ext_mem_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // wishbone slave
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [ext_mem_pkg::ADR_W-1:0] adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  // core request port
  input  wire logic                         req_i,
  input  wire logic                         req_wide_i,
  input  wire logic                         req_we_i,
  input  wire logic [15:0]                  ptr16_i,
  input  wire logic [7:0]                   ind_lo_i,
  input  wire logic [7:0]                   wdata_i,
  output logic                              busy_o,
  output logic                              done_o,
  output logic      [7:0]                   rdata_o,
  // on-chip ram
  output logic                              on_chip_ext_ram_req_o,
  output logic                              on_chip_ext_ram_we_o,
  output logic [ext_mem_pkg::ON_CHIP_EXT_RAM_AW-1:0]   on_chip_ext_ram_addr_o,
  // port ownership
  output logic                              grp_lo_own_o,
  output logic                              grp_hi_own_o,
  // pins
  output logic      [7:0]                   addr_hi_o,
  output logic                              addr_hi_oe_o,
  output logic      [7:0]                   addr_lo_o,
  output logic                              addr_lo_oe_o,
  input  wire logic [7:0]                   data_i,
  output logic      [7:0]                   data_o,
  output logic                              data_oe_o,
  output logic                              ale_o,
  output logic                              rd_n_o,
  output logic                              wr_n_o,
  output logic                              ctl_oe_o
);
  import ext_mem_pkg::*;

  // ******************************
  // registers and bus slave
  // ******************************
  logic [7:0]      config_q;
  logic [7:0]      page_q;
  logic [7:0]      timing_q;
  logic [31:0]     dat_q;
  logic            ack_q;
  logic [9:0]      idx;
  logic            bus_req;
  logic            bus_wr;

  assign idx     = adr_i[ADR_W-1:2];
  assign bus_req = cyc_i && stb_i && !ack_q;
  assign bus_wr  = bus_req && we_i && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_q <= CONFIG_RST;
      page_q   <= PAGE_RST;
      timing_q <= TIMING_RST;
    end else if (bus_wr) begin
      if (idx == IDX_CONFIG) begin
        config_q <= dat_i[7:0] & CONFIG_MASK;
      end
      if (idx == IDX_PAGE) begin
        page_q <= dat_i[7:0];
      end
      if (idx == IDX_TIMING) begin
        timing_q <= dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= bus_req;
      dat_q <= 32'h0;
      if (bus_req && !we_i) begin
        unique case (idx)
          IDX_CONFIG: dat_q <= {24'h0, config_q};
          IDX_PAGE:   dat_q <= {24'h0, page_q};
          IDX_TIMING: dat_q <= {24'h0, timing_q};
          IDX_STATUS: dat_q <= {30'h0, done_o, busy_o};
          default:    dat_q <= 32'h0;
        endcase
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ******************************
  // field decode
  // ******************************
  logic            port_group_select;
  logic            bus_mux_select;
  logic [1:0]      memory_map_mode;
  logic [1:0]      latch_strobe_width;
  logic [1:0]      setup_code;
  logic [3:0]      strobe_code;
  logic [1:0]      hold_code;
  logic            muxed;

  assign port_group_select  = config_q[CF_PORT_SEL];
  assign bus_mux_select     = config_q[CF_MUX_SEL];
  assign memory_map_mode    = config_q[CF_MODE_HI:CF_MODE_LO];
  assign latch_strobe_width = config_q[CF_ALE_HI:CF_ALE_LO];
  assign setup_code         = timing_q[TC_SETUP_HI:TC_SETUP_LO];
  assign strobe_code        = timing_q[TC_STRB_HI:TC_STRB_LO];
  assign hold_code          = timing_q[TC_HOLD_HI:TC_HOLD_LO];
  assign muxed              = !bus_mux_select;

  // ******************************
  // address routing
  // ******************************
  logic [15:0]     eff_addr;
  logic            go_off;
  logic            hi_drive;
  logic [7:0]      hi_byte;

  always_comb begin
    eff_addr = req_wide_i ? ptr16_i : {page_q, ind_lo_i};
    unique case (memory_map_mode)
      MODE_INT:   go_off = 1'b0;
      MODE_EXT:   go_off = 1'b1;
      default:    go_off = (eff_addr >= ONCHIP_TOP);
    endcase
    hi_byte  = req_wide_i ? ptr16_i[15:8] : page_q;
    hi_drive = req_wide_i || (memory_map_mode == MODE_BANK);
  end

  // ******************************
  // transfer sequencer
  // ******************************
  xfer_state_type  state_q;
  xfer_state_type  state_d;
  logic            load;
  logic [3:0]      load_val;
  logic            zero;
  logic            we_q;
  logic [7:0]      wdata_q;

  phase_timer #(
    .W       (CNT_W)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (load),
    .value_i (load_val),
    .zero_o  (zero)
  );

  always_comb begin
    state_d  = state_q;
    load     = 1'b0;
    load_val = 4'h0;
    unique case (state_q)
      st_idle: begin
        if (req_i && go_off) begin
          state_d = st_start;
        end
      end
      st_start: begin
        load = 1'b1;
        if (muxed) begin
          state_d  = st_ale_hi;
          load_val = {2'b00, latch_strobe_width};
        end else if (setup_code != 2'h0) begin
          state_d  = st_setup;
          load_val = {2'b00, setup_code - 2'h1};
        end else begin
          state_d  = st_strobe;
          load_val = strobe_code;
        end
      end
      st_ale_hi: begin
        if (zero) begin
          state_d  = st_ale_lo;
          load     = 1'b1;
          load_val = {2'b00, latch_strobe_width};
        end
      end
      st_ale_lo: begin
        if (zero) begin
          load = 1'b1;
          if (setup_code != 2'h0) begin
            state_d  = st_setup;
            load_val = {2'b00, setup_code - 2'h1};
          end else begin
            state_d  = st_strobe;
            load_val = strobe_code;
          end
        end
      end
      st_setup: begin
        if (zero) begin
          state_d  = st_strobe;
          load     = 1'b1;
          load_val = strobe_code;
        end
      end
      st_strobe: begin
        if (zero) begin
          load = 1'b1;
          if (hold_code != 2'h0) begin
            state_d  = st_hold;
            load_val = {2'b00, hold_code - 2'h1};
          end else begin
            state_d  = st_fin;
            load_val = FIN_LAST;
          end
        end
      end
      st_hold: begin
        if (zero) begin
          state_d  = st_fin;
          load     = 1'b1;
          load_val = FIN_LAST;
        end
      end
      st_fin: begin
        if (zero) begin
          state_d = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // ******************************
  // request capture and core answers
  // ******************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      we_q        <= 1'b0;
      wdata_q     <= 8'h00;
      on_chip_ext_ram_req_o  <= 1'b0;
      on_chip_ext_ram_we_o   <= 1'b0;
      on_chip_ext_ram_addr_o <= '0;
      done_o      <= 1'b0;
      busy_o      <= 1'b0;
      rdata_o     <= 8'h00;
    end else begin
      on_chip_ext_ram_req_o <= 1'b0;
      done_o     <= 1'b0;
      busy_o     <= (state_d != st_idle);
      if (state_q == st_idle && req_i) begin
        we_q    <= req_we_i;
        wdata_q <= wdata_i;
        if (!go_off) begin
          on_chip_ext_ram_req_o  <= 1'b1;
          on_chip_ext_ram_we_o   <= req_we_i;
          on_chip_ext_ram_addr_o <= eff_addr[ON_CHIP_EXT_RAM_AW-1:0];
          done_o      <= 1'b1;
        end
      end
      if (state_q == st_strobe && zero && !we_q) begin
        rdata_o <= data_i;
      end
      if (state_q == st_fin && zero) begin
        done_o <= 1'b1;
      end
    end
  end

  // ******************************
  // pin drive
  // ******************************
  logic            active_d;
  logic            addr_phase_d;
  logic            data_phase_d;

  assign active_d     = (state_d != st_idle);
  assign addr_phase_d = (state_d == st_start) || (state_d == st_ale_hi)
                        || (state_d == st_ale_lo);
  assign data_phase_d = (state_d == st_setup) || (state_d == st_strobe)
                        || (state_d == st_hold);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grp_lo_own_o <= 1'b0;
      grp_hi_own_o <= 1'b0;
      ctl_oe_o     <= 1'b0;
      ale_o        <= 1'b0;
      rd_n_o       <= 1'b1;
      wr_n_o       <= 1'b1;
    end else begin
      grp_lo_own_o <= active_d && !port_group_select;
      grp_hi_own_o <= active_d && port_group_select;
      ctl_oe_o     <= active_d;
      ale_o        <= (state_d == st_ale_hi);
      rd_n_o       <= !((state_d == st_strobe) && !we_q);
      wr_n_o       <= !((state_d == st_strobe) && we_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_hi_o    <= 8'h00;
      addr_hi_oe_o <= 1'b0;
      addr_lo_o    <= 8'h00;
      addr_lo_oe_o <= 1'b0;
    end else if (state_q == st_idle && req_i && go_off) begin
      addr_hi_o    <= hi_byte;
      addr_hi_oe_o <= hi_drive;
      addr_lo_o    <= eff_addr[7:0];
      addr_lo_oe_o <= !muxed;
    end else if (!active_d) begin
      addr_hi_oe_o <= 1'b0;
      addr_lo_oe_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else if (muxed && addr_phase_d) begin
      data_o    <= (state_q == st_idle) ? eff_addr[7:0]
                   : addr_lo_o;
      data_oe_o <= 1'b1;
    end else begin
      data_o    <= wdata_q;
      data_oe_o <= data_phase_d && we_q;
    end
  end
endmodule // ext_mem_if

// ==== testbench/ext_mem_monitor.sv ====
// port checker for the external memory interface
`timescale 1ns/100ps
module ext_mem_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        we_i,
  input wire logic [11:0] adr_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        on_chip_ext_ram_req_o,
  input wire logic        grp_lo_own_o,
  input wire logic        grp_hi_own_o,
  input wire logic        addr_hi_oe_o,
  input wire logic        addr_lo_oe_o,
  input wire logic        data_oe_o,
  input wire logic        ale_o,
  input wire logic        rd_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_cfg_top_zero: assert property (ack_o && !we_i && adr_i == 12'h28c
    |-> dat_o[7:6] == 2'b00) else $error("config top bits not zero");
  a_one_group: assert property (!(grp_lo_own_o && grp_hi_own_o))
    else $error("both port groups owned");
  a_own_in_xfer: assert property ((grp_lo_own_o || grp_hi_own_o
    || addr_hi_oe_o) |-> busy_o) else $error("pins owned while idle");
  a_read_no_drive: assert property (!rd_n_o |-> !data_oe_o)
    else $error("data driven during read");
  a_ale_mux_only: assert property (ale_o |-> !addr_lo_oe_o)
    else $error("latch strobe in separate-bus mode");
  a_ale_drives_ad: assert property (ale_o |-> data_oe_o && busy_o)
    else $error("address not on shared pins");
  a_ale_max_width: assert property (ale_o [*4] |=> !ale_o)
    else $error("latch strobe too long");
  a_onchip_quick: assert property (on_chip_ext_ram_req_o |-> done_o && !busy_o)
    else $error("on-chip access not single cycle");
  a_min_xfer: assert property ($rose(busy_o) |-> busy_o [*5])
    else $error("transfer below five cycles");
  a_mux_min_len: assert property ($rose(ale_o) |-> busy_o [*5])
    else $error("muxed transfer too short");
  a_end_done: assert property ($fell(busy_o) && !$past(rst_i)
    |-> done_o) else $error("transfer ended without done");
endmodule // ext_mem_monitor

// ==== testbench/ext_mem_partner.sv ====
// off-chip memory with address latch
`timescale 1ns/100ps
module ext_mem_partner (
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] addr_hi_i,
  input  wire logic       addr_hi_oe_i,
  input  wire logic [7:0] addr_lo_i,
  input  wire logic       addr_lo_oe_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o
);
  logic [7:0]  mem [65536];
  logic [7:0]  latch_q;
  logic [7:0]  last_q = 8'h00;
  logic [15:0] addr;
  // transparent while strobe high, holds after fall
  always @* if (ale_i) latch_q = data_i;
  assign addr = {addr_hi_oe_i ? addr_hi_i : 8'h00,
                 addr_lo_oe_i ? addr_lo_i : latch_q};
  always @(posedge clk_i) begin
    if (!wr_n_i) mem[addr] <= data_i;
    if (!rd_n_i) last_q <= mem[addr];
  end
  // released bus shows inverse of last value
  assign data_o = !rd_n_i ? mem[addr] : ~last_q;
endmodule // ext_mem_partner

// ==== testbench/ext_mem_if_tb.sv ====
// self-checking bench for the external memory interface
`timescale 1ns/100ps
module ext_mem_if_tb;
  import ext_mem_pkg::*;
  localparam logic [11:0] A_CFG = {IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_PAG = {IDX_PAGE, 2'b00};
  localparam logic [11:0] A_TIM = {IDX_TIMING, 2'b00};
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [11:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic        req_i, req_wide_i, req_we_i, busy_o, done_o;
  logic [15:0] ptr16_i, ea;
  logic [7:0]  ind_lo_i, wdata_i, rdata_o, data_i, data_o, addr_hi_o;
  logic [7:0]  addr_lo_o, tm, cf, pg, wd, hi, rd;
  logic [12:0] on_chip_ext_ram_addr_o, xa;
  logic        on_chip_ext_ram_req_o, on_chip_ext_ram_we_o, grp_lo_own_o, grp_hi_own_o;
  logic        addr_hi_oe_o, addr_lo_oe_o, data_oe_o, ale_o, rd_n_o;
  logic        wr_n_o, ctl_oe_o, onc, off, hi_oe, lo_oe, xw, ctl;
  logic [1:0]  own;
  int          err_count, check_count, n;
  ext_mem_if i_ext_mem_if (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i(4'h1), .dat_i, .dat_o, .ack_o, .req_i, .req_wide_i, .req_we_i,
    .ptr16_i, .ind_lo_i, .wdata_i, .busy_o, .done_o, .rdata_o, .on_chip_ext_ram_req_o,
    .on_chip_ext_ram_we_o, .on_chip_ext_ram_addr_o, .grp_lo_own_o, .grp_hi_own_o, .addr_hi_o,
    .addr_hi_oe_o, .addr_lo_o, .addr_lo_oe_o, .data_i, .data_o, .data_oe_o,
    .ale_o, .rd_n_o, .wr_n_o, .ctl_oe_o);
  ext_mem_partner i_ext_mem_partner (.clk_i, .ale_i(ale_o), .rd_n_i(rd_n_o),
    .wr_n_i(wr_n_o), .addr_hi_i(addr_hi_o), .addr_hi_oe_i(addr_hi_oe_o),
    .addr_lo_i(addr_lo_o), .addr_lo_oe_i(addr_lo_oe_o), .data_i(data_o),
    .data_o(data_i));
  // ******************************
  // tasks
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // off-chip length: start, latch phases, setup, strobe, hold, finish
  function automatic int exp_len(input logic [7:0] c, input logic [7:0] t);
    return 1 + (c[4] ? 0 : 2 * (c[1:0] + 1)) + t[7:6] + t[5:2] + 1
      + t[1:0] + 3;
  endfunction
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic xfer(input logic w);
    req_we_i <= w;
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    onc = 1'b0;
    do begin
      @(posedge clk_i);
      n += int'(busy_o);
      if (!rd_n_o || !wr_n_o) begin
        hi_oe = addr_hi_oe_o;
        hi = addr_hi_o;
        lo_oe = addr_lo_oe_o;
        own = {grp_hi_own_o, grp_lo_own_o};
        ctl = ctl_oe_o;
      end
      if (on_chip_ext_ram_req_o) begin
        onc = 1'b1;
        xa = on_chip_ext_ram_addr_o;
        xw = on_chip_ext_ram_we_o;
      end
    end while (done_o !== 1'b1);
    rd = rdata_o;
    check(onc, !off);
    check(ctl_oe_o, 1'b0);
    if (!off) begin
      check(xa, ea[12:0]);
      check(xw, w);
    end else begin
      check(n, exp_len(cf, tm));
      check(hi_oe, cf[3:2] == 2'b10 || req_wide_i);
      if (hi_oe) check(hi, req_wide_i ? ptr16_i[15:8] : pg);
      check(lo_oe, cf[4]);
      check(own, cf[5] ? 2'b10 : 2'b01);
      check(ctl, 1'b1);
    end
  endtask
  // ******************************
  // stimulus
  // ******************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    err_count++;
    results();
  end
  initial begin
    {cyc_i, stb_i, we_i, req_i, req_wide_i, req_we_i} = 6'h00;
    {adr_i, dat_i, ptr16_i, ind_lo_i, wdata_i} = '0;
    rst_i = 1'b1;
    void'($urandom(32'h960b));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, A_CFG, 8'h00);
    check(q, 32'h03);
    wb(1'b0, A_TIM, 8'h00);
    check(q, 32'hff);
    wb(1'b1, A_CFG, 8'hff);
    wb(1'b0, A_CFG, 8'h00);
    check(q, 32'h3f);
    wb(1'b1, 12'hffc, 8'h5a);
    wb(1'b0, 12'hffc, 8'h00);
    check(q, 32'h0);
    for (int i = 0; i < 48; i++) begin
      tm = 8'($urandom);
      cf = 8'($urandom);
      pg = 8'($urandom);
      ea = 16'($urandom);
      req_wide_i <= 1'($urandom);
      if (i < 4) cf[3:2] = 2'(i);
      if (i == 4) begin
        cf[3:2] = 2'b01;
        ea = 16'h2000;
        req_wide_i <= 1'b1;
      end
      if (i == 5) begin
        cf[3:2] = 2'b01;
        pg = 8'h20;
        req_wide_i <= 1'b0;
      end
      wb(1'b1, A_TIM, tm);
      wb(1'b1, A_CFG, cf);
      wb(1'b1, A_PAG, pg);
      if (!req_wide_i) ea = {pg, ea[7:0]};
      ptr16_i <= ea;
      ind_lo_i <= ea[7:0];
      wd = 8'($urandom);
      wdata_i <= wd;
      off = cf[3:2] == 2'b11 || (cf[3:2] != 2'b00 && ea >= 16'h2000);
      xfer(1'b1);
      xfer(1'b0);
      if (off) check(rd, wd);
    end
    results();
  end
endmodule // ext_mem_if_tb
bind ext_mem_if ext_mem_monitor i_ext_mem_monitor (.clk_i, .rst_i, .we_i,
  .adr_i, .ack_o, .dat_o, .busy_o, .done_o, .on_chip_ext_ram_req_o, .grp_lo_own_o,
  .grp_hi_own_o, .addr_hi_oe_o, .addr_lo_oe_o, .data_oe_o, .ale_o, .rd_n_o);
